// ===== core/protocol_select_config.sv
// Protocol select and type B transmit framing register bank.
// Assumes register port strobes come from logic on clock_i; enable is an
// asynchronous pin and is synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "proto_cfg_defs.svh"

// Overview of operation
// - Protocol select presets to 0x02 while enable low or power-on reset.
// - Bit 7 set means replies carry no CRC; clear means CRC expected.
// - No-CRC setting takes effect only for type A and vicinity protocols.
// - Bit 6 picks direct mode 1 (custom framing) over mode 0 (raw).
// - Bits 4 to 0 select air protocol and receive bit rate.
// - Codes 0-7 are vicinity; bit 0 picks 1-of-256, bit 1 high rate.
// - Code bit 2 within vicinity codes selects the double subcarrier.
// - Codes 8-11 are type A at 106, 212, 424, 848 kbps.
// - Codes 12-15 are type B at 106, 212, 424, 848 kbps.
// - Transmit options reset to zero on power-on reset or enable low.
// - Bits 7 to 5 give extra guard time units between type B characters.
// - Bit 4 sets end marker low phase to 11 units, else 10.
// - Bit 3 sets start marker high phase to 3 units, else 2.
// - Bit 2 sets start marker low phase to 11 units, else 10.
// - Bit 1 keeps guard time after last byte; clear omits it.
// - Framing and guard settings apply only to type B transmission.
// - Each protocol select write returns rate/parity and timer-high registers to presets.
module protocol_select_config (
  // Clock and power-on reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // Enable pin, asynchronous
  input  wire logic       enable_i,
  // Register port
  input  wire logic [4:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic [7:0]      reg_rdata_o,
  // Receive configuration
  output logic [4:0]      family_o,
  output logic [1:0]      rx_rate_o,
  output logic            high_rate_o,
  output logic            double_sc_o,
  output logic            coding_256_o,
  output logic            crc_omit_o,
  output logic            direct_mode1_o,
  // Type B transmit framing
  output logic [2:0]      guard_time_count_o,
  output logic [3:0]      frame_end_low_length_o,
  output logic [1:0]      frame_start_high_length_o,
  output logic [3:0]      frame_start_low_length_o,
  output logic            guard_after_last_o,
  // Preset pulse for neighbouring option registers
  output logic            proto_write_o
);

  // Marker length pick, shared by both low phases
  function automatic logic [3:0] low_len(input logic long_sel);
    low_len = long_sel ? `ETU_LOW_LONG : `ETU_LOW_SHORT;
  endfunction : low_len

  logic [7:0]                       psc_r;
  logic [7:1]                       txo_r;
  logic                             en_s1_r;
  logic                             en_s2_r;
  logic                             en_s3_r;
  logic                             en_ok_r;
  logic                             wr_psc;
  logic                             wr_txo;
  logic                             crc_applies;
  logic                             is_type_b;
  proto_cfg_pkg::protocol_family_t  fam;
  logic [1:0]                       dec_rate;
  logic                             dec_high;
  logic                             dec_dsc;
  logic                             dec_256;

  // Enable pin synchroniser; a level counts once stages two and three agree
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      en_s3_r <= 1'b0;
      en_ok_r <= 1'b0;
    end else begin
      en_s1_r <= enable_i;
      en_s2_r <= en_s1_r;
      en_s3_r <= en_s2_r;
      if (en_s2_r == en_s3_r) begin
        en_ok_r <= en_s3_r;
      end
    end
  end

  // Writes while disabled are dropped; the bank is held at preset then
  assign wr_psc = reg_wr_i && en_ok_r && (reg_addr_i == `PSC_ADDR);
  assign wr_txo = reg_wr_i && en_ok_r && (reg_addr_i == `TXO_ADDR);

  // Protocol select register; bit 5 stored as written, no hardware effect
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      psc_r <= `PSC_RESET;
    end else if (!en_ok_r) begin
      psc_r <= `PSC_RESET;
    end else if (wr_psc) begin
      psc_r <= reg_wdata_i;
    end
  end

  // Transmit options register; bit 0 has no storage
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      txo_r <= 7'(`TXO_RESET >> 1);
    end else if (!en_ok_r) begin
      txo_r <= 7'(`TXO_RESET >> 1);
    end else if (wr_txo) begin
      txo_r <= reg_wdata_i[7:1];
    end
  end

  // One-cycle preset pulse per protocol select write
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      proto_write_o <= 1'b0;
    end else begin
      proto_write_o <= wr_psc;
    end
  end

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= `RDATA_IDLE;
    end else if (reg_rd_i && reg_addr_i == `PSC_ADDR) begin
      reg_rdata_o <= psc_r;
    end else if (reg_rd_i && reg_addr_i == `TXO_ADDR) begin
      reg_rdata_o <= {txo_r, 1'b0};
    end else if (reg_rd_i) begin
      reg_rdata_o <= `RDATA_IDLE;
    end
  end

  protocol_code_decode u_decode (
    .code_i       (psc_r[`PSC_CODE_MSB:`PSC_CODE_LSB]),
    .family_o     (fam),
    .rx_rate_o    (dec_rate),
    .high_rate_o  (dec_high),
    .double_sc_o  (dec_dsc),
    .coding_256_o (dec_256)
  );

  // CRC omission only for type A and vicinity
  assign crc_applies = (fam == proto_cfg_pkg::FAM_ISO_A) || (fam == proto_cfg_pkg::FAM_VICINITY);
  assign is_type_b   = (fam == proto_cfg_pkg::FAM_ISO_B);

  // Receive side outputs, registered so the top drives only flops
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      family_o       <= proto_cfg_pkg::FAM_VICINITY;
      rx_rate_o      <= `RATE_106;
      high_rate_o    <= 1'b1;
      double_sc_o    <= 1'b0;
      coding_256_o   <= 1'b0;
      crc_omit_o     <= 1'b0;
      direct_mode1_o <= 1'b0;
    end else begin
      family_o       <= fam;
      rx_rate_o      <= dec_rate;
      high_rate_o    <= dec_high;
      double_sc_o    <= dec_dsc;
      coding_256_o   <= dec_256;
      // Decoder told whether a CRC follows
      crc_omit_o     <= psc_r[`PSC_NO_RX_CRC] && crc_applies;
      direct_mode1_o <= psc_r[`PSC_DIRECT_TYPE];
    end
  end

  // Type B framing; other protocols see the short defaults and no guard
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      guard_time_count_o        <= `GUARD_NONE;
      frame_end_low_length_o    <= `ETU_LOW_SHORT;
      frame_start_high_length_o <= `ETU_HIGH_SHORT;
      frame_start_low_length_o  <= `ETU_LOW_SHORT;
      guard_after_last_o        <= 1'b0;
    end else if (is_type_b) begin
      // Settings applied for type B only
      guard_time_count_o        <= txo_r[`TXO_GUARD_MSB:`TXO_GUARD_LSB];
      frame_end_low_length_o    <= low_len(txo_r[`TXO_EOF_LOW]);
      frame_start_high_length_o <= txo_r[`TXO_SOF_HIGH] ? `ETU_HIGH_LONG : `ETU_HIGH_SHORT;
      frame_start_low_length_o  <= low_len(txo_r[`TXO_SOF_LOW]);
      guard_after_last_o        <= txo_r[`TXO_GUARD_LAST];
    end else begin
      guard_time_count_o        <= `GUARD_NONE;
      frame_end_low_length_o    <= `ETU_LOW_SHORT;
      frame_start_high_length_o <= `ETU_HIGH_SHORT;
      frame_start_low_length_o  <= `ETU_LOW_SHORT;
      guard_after_last_o        <= 1'b0;
    end
  end

  // Checks on the bank and its decoded outputs
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence psc_write_s;
    wr_psc;
  endsequence

  sequence preset_pulse_s;
    proto_write_o ##1 (!proto_write_o || $past(wr_psc));
  endsequence

  chk_psc_preset_disable: assert property (
    !en_ok_r |=> psc_r == `PSC_RESET
  ) else $error("protocol select not preset while disabled");

  chk_txo_preset_disable: assert property (
    !en_ok_r |=> txo_r == 7'h00
  ) else $error("transmit options not cleared while disabled");

  chk_crc_omit_gate: assert property (
    ##1 crc_omit_o == ($past(psc_r[7]) && $past(crc_applies))
  ) else $error("crc omit output wrong");

  chk_crc_other_proto: assert property (
    (fam == proto_cfg_pkg::FAM_ISO_B || fam == proto_cfg_pkg::FAM_CARD) |=> !crc_omit_o
  ) else $error("crc omit set outside type A and vicinity");

  chk_direct_type_follow: assert property (
    $changed(psc_r[6]) |=> direct_mode1_o == $past(psc_r[6])
  ) else $error("direct mode type not followed");

  chk_vicinity_fields: assert property (
    psc_r[4:3] == 2'h0 |=> family_o == 5'b00001 && coding_256_o == $past(psc_r[0])
      && high_rate_o == $past(psc_r[1])
  ) else $error("vicinity decode wrong");

  chk_double_subcarrier: assert property (
    psc_r[4:2] == 3'h1 |=> double_sc_o
  ) else $error("double subcarrier not selected");

  chk_type_a_rate: assert property (
    psc_r[4:2] == 3'h2 |=> family_o == 5'b00010 && rx_rate_o == $past(psc_r[1:0])
  ) else $error("type A decode wrong");

  chk_type_b_rate: assert property (
    psc_r[4:2] == 3'h3 |=> family_o == 5'b00100 && rx_rate_o == $past(psc_r[1:0])
  ) else $error("type B decode wrong");

  chk_guard_count_field: assert property (
    is_type_b |=> guard_time_count_o == $past(txo_r[7:5])
  ) else $error("guard count not taken from register");

  chk_eof_low_len: assert property (
    is_type_b && txo_r[4] |=> frame_end_low_length_o == 4'hb
  ) else $error("end marker low length wrong");

  chk_sof_high_len: assert property (
    is_type_b && !txo_r[3] |=> frame_start_high_length_o == 2'h2
  ) else $error("start marker high length wrong");

  chk_sof_low_len: assert property (
    is_type_b && !txo_r[2] |=> frame_start_low_length_o == 4'ha
  ) else $error("start marker low length wrong");

  chk_guard_last_byte: assert property (
    is_type_b |=> guard_after_last_o == $past(txo_r[1])
  ) else $error("guard after last byte wrong");

  chk_framing_non_b: assert property (
    !is_type_b |=> guard_time_count_o == 3'h0 && !guard_after_last_o
  ) else $error("type B framing leaked to other protocol");

  chk_preset_pulse_write: assert property (
    psc_write_s |=> preset_pulse_s
  ) else $error("preset pulse missing after protocol write");

  chk_reserved_bit_zero: assert property (
    reg_rd_i && reg_addr_i == 5'h02 |=> reg_rdata_o[0] == 1'b0
  ) else $error("reserved bit reads non-zero");

  chk_psc_write_lands: assert property (
    psc_write_s |=> psc_r == $past(reg_wdata_i)
  ) else $error("protocol select write not stored");

  chk_txo_write_lands: assert property (
    wr_txo |=> txo_r == $past(reg_wdata_i[7:1])
  ) else $error("transmit options write not stored");

  chk_psc_readback: assert property (
    reg_rd_i && reg_addr_i == `PSC_ADDR |=> reg_rdata_o == $past(psc_r)
  ) else $error("protocol select read back wrong");

endmodule : protocol_select_config
`default_nettype wire

// ===== core/proto_cfg_defs.svh
// Register map, reset values and field positions of the protocol select bank.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PROTO_CFG_DEFS_SVH
`define PROTO_CFG_DEFS_SVH

// Register addresses on the register port
`define PSC_ADDR          5'h01
`define TXO_ADDR          5'h02

// Reset values
`define PSC_RESET         8'h02
`define TXO_RESET         8'h00
`define RDATA_IDLE        8'h00

// Protocol select fields
`define PSC_NO_RX_CRC     7
`define PSC_DIRECT_TYPE   6
`define PSC_TAG_MODE      5
`define PSC_CODE_MSB      4
`define PSC_CODE_LSB      0

// Protocol code groups (upper two bits for vicinity, upper three for type A and B) and card codes
`define CODE_GRP_15693    2'h0
`define CODE_GRP_ISO_A    3'h2
`define CODE_GRP_ISO_B    3'h3
`define CODE_CARD_212     5'h1a
`define CODE_CARD_424     5'h1b
`define RATE_212          2'h1
`define RATE_424          2'h2
`define RATE_106          2'h0

// Transmit options fields
`define TXO_GUARD_MSB     7
`define TXO_GUARD_LSB     5
`define TXO_EOF_LOW       4
`define TXO_SOF_HIGH      3
`define TXO_SOF_LOW       2
`define TXO_GUARD_LAST    1
`define GUARD_NONE        3'h0

// Marker phase lengths in elementary time units
`define ETU_LOW_SHORT     4'ha
`define ETU_LOW_LONG      4'hb
`define ETU_HIGH_SHORT    2'h2
`define ETU_HIGH_LONG     2'h3

`endif

// ===== core/proto_cfg_pkg.sv
// Types shared by the protocol select bank and its code decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package proto_cfg_pkg;

  // Air protocol family, one-hot
  typedef enum logic [4:0] {
    FAM_VICINITY = 5'b00001,
    FAM_ISO_A    = 5'b00010,
    FAM_ISO_B    = 5'b00100,
    FAM_CARD     = 5'b01000,
    FAM_RSVD     = 5'b10000
  } protocol_family_t;

endpackage : proto_cfg_pkg

// ===== core/protocol_code_decode.sv
// Decoder of the five-bit protocol code into family and rate fields.
// Assumes a stable code from the register bank; purely combinational.
`timescale 1ns/100ps
`default_nettype none
`include "proto_cfg_defs.svh"

module protocol_code_decode (
  // Code in
  input  wire logic [4:0]                    code_i,
  // Decoded fields
  output var  proto_cfg_pkg::protocol_family_t family_o,
  output logic [1:0]                         rx_rate_o,
  output logic                               high_rate_o,
  output logic                               double_sc_o,
  output logic                               coding_256_o
);

  // Code groups; unlisted codes fall to reserved
  always_comb begin
    family_o     = proto_cfg_pkg::FAM_RSVD;
    rx_rate_o    = `RATE_106;
    high_rate_o  = 1'b0;
    double_sc_o  = 1'b0;
    coding_256_o = 1'b0;
    if (code_i[4:3] == `CODE_GRP_15693) begin
      family_o     = proto_cfg_pkg::FAM_VICINITY;
      coding_256_o = code_i[0];
      high_rate_o  = code_i[1];
      double_sc_o  = code_i[2];
    end else if (code_i[4:2] == `CODE_GRP_ISO_A) begin
      family_o  = proto_cfg_pkg::FAM_ISO_A;
      rx_rate_o = code_i[1:0];
    end else if (code_i[4:2] == `CODE_GRP_ISO_B) begin
      family_o  = proto_cfg_pkg::FAM_ISO_B;
      rx_rate_o = code_i[1:0];
    end else if (code_i == `CODE_CARD_212) begin
      family_o  = proto_cfg_pkg::FAM_CARD;
      rx_rate_o = `RATE_212;
    end else if (code_i == `CODE_CARD_424) begin
      family_o  = proto_cfg_pkg::FAM_CARD;
      rx_rate_o = `RATE_424;
    end
  end

endmodule : protocol_code_decode
`default_nettype wire

// ===== sim/host_port_model.sv
// Host model driving the register port of the protocol select bank.
// Assumes one free-running clock; strobes are one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none

module host_port_model (
  // Clock
  input  wire logic       clock_i,
  // Register port
  output logic [4:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  // Idle port at time zero
  initial begin
    reg_addr_o = 5'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'h0;
    reg_rd_o = 1'h0;
  end

  // Protocol select writes go out with bit 5 cleared; other data as given
  task automatic write_reg(input logic [4:0] addr, input logic [7:0] data);
    @(posedge clock_i);
    reg_addr_o <= addr;
    reg_wdata_o <= (addr == 5'h01) ? (data & 8'hdf) : data;
    reg_wr_o <= 1'h1;
    @(posedge clock_i);
    reg_wr_o <= 1'h0;
    reg_wdata_o <= ~data; // Released data must not look stable
    #1;
  endtask : write_reg

  // Read data taken one cycle after the strobe edge
  task automatic read_reg(input logic [4:0] addr, output logic [7:0] data);
    @(posedge clock_i);
    reg_addr_o <= addr;
    reg_rd_o <= 1'h1;
    @(posedge clock_i);
    reg_rd_o <= 1'h0;
    #1;
    data = reg_rdata_i;
  endtask : read_reg
endmodule : host_port_model

`default_nettype wire

// ===== sim/protocol_select_config_tb_top.sv
// Self-checking bench of the protocol select bank.
// Assumes the host model in its own file; one 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module protocol_select_config_tb_top;
  logic       clock_i, rst_i, enable_i;
  logic [4:0] reg_addr, family_o;
  logic [7:0] reg_wdata, reg_rdata_o, rd;
  logic       reg_wr, reg_rd, high_rate_o, double_sc_o, coding_256_o, crc_omit_o, direct_mode1_o;
  logic [1:0] rx_rate_o, frame_start_high_length_o;
  logic [2:0] guard_time_count_o;
  logic [3:0] frame_end_low_length_o, frame_start_low_length_o;
  logic       guard_after_last_o, proto_write_o;
  int         n_mismatch, checks_done;
  logic [7:0] txv [5] = '{8'hff, 8'h00, 8'ha5, 8'h5a, 8'h13};
  logic [15:0] rx_cfg, tx_cfg;

  assign rx_cfg = {4'h0, family_o, rx_rate_o, high_rate_o, double_sc_o, coding_256_o, crc_omit_o, direct_mode1_o};
  assign tx_cfg = {2'h0, guard_time_count_o, frame_end_low_length_o, frame_start_high_length_o,
                   frame_start_low_length_o, guard_after_last_o};

  protocol_select_config DUT (.clock_i(clock_i), .rst_i(rst_i), .enable_i(enable_i), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata_o),
    .family_o(family_o), .rx_rate_o(rx_rate_o), .high_rate_o(high_rate_o), .double_sc_o(double_sc_o),
    .coding_256_o(coding_256_o), .crc_omit_o(crc_omit_o), .direct_mode1_o(direct_mode1_o),
    .guard_time_count_o(guard_time_count_o), .frame_end_low_length_o(frame_end_low_length_o),
    .frame_start_high_length_o(frame_start_high_length_o), .frame_start_low_length_o(frame_start_low_length_o),
    .guard_after_last_o(guard_after_last_o), .proto_write_o(proto_write_o));

  host_port_model host (.clock_i(clock_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata_o));

  // Clock, half period toggling
  initial clock_i = 1'h0;
  always #12.5 clock_i = ~clock_i;

  // Compare of register read data
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_reg

  // Compare of decoded outputs
  task automatic chk_out(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_out

  // Write, then watch the preset pulse; returns once decoded outputs settle
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic en);
    host.write_reg(a, d);
    chk_out(16'(proto_write_o), 16'(en && a == 5'h01), "pulse");
    @(posedge clock_i);
    #1;
    chk_out(16'(proto_write_o), 16'h0, "pulse end");
  endtask : wr

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    host.read_reg(a, rd);
    chk_reg(rd, exp, "read");
  endtask : rd_chk

  function automatic logic [4:0] fam_of(input logic [4:0] c);
    if (c < 5'h08) return 5'h01;
    if (c < 5'h0c) return 5'h02;
    if (c < 5'h10) return 5'h04;
    if (c == 5'h1a || c == 5'h1b) return 5'h08;
    return 5'h10;
  endfunction : fam_of

  // Short markers and no guard unless type B
  function automatic logic [15:0] tx_exp(input logic [7:0] d, input logic tb);
    if (!tb) return {2'h0, 3'h0, 4'ha, 2'h2, 4'ha, 1'h0};
    return {2'h0, d[7:5], d[4] ? 4'hb : 4'ha, d[3] ? 2'h3 : 2'h2, d[2] ? 4'hb : 4'ha, d[1]};
  endfunction : tx_exp

  task automatic test_reset;
    rd_chk(5'h01, 8'h02);
    rd_chk(5'h02, 8'h00);
    chk_out(rx_cfg, {4'h0, 5'h01, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0}, "rx preset");
    chk_out(tx_cfg, tx_exp(8'h00, 1'h0), "tx preset");
    $display("test reset done");
  endtask : test_reset

  // Every code, with the CRC and direct bits varied alongside
  task automatic test_codes;
    logic [4:0] c, f;
    logic [7:0] d;
    logic [1:0] r;
    for (int i = 0; i < 32; i++) begin
      c = 5'(i);
      d = {c[1] ^ c[0], c[2], 1'h0, c};
      f = fam_of(c);
      r = (f == 5'h02 || f == 5'h04) ? c[1:0] : (f == 5'h08) ? (c[0] ? 2'h2 : 2'h1) : 2'h0;
      wr(5'h01, d, 1'h1);
      chk_out({7'h0, family_o, rx_rate_o}, {7'h0, f, r}, "family rate");
      chk_out(16'(crc_omit_o), 16'(d[7] && (f == 5'h01 || f == 5'h02)), "crc");
      chk_out(16'(direct_mode1_o), 16'(d[6]), "direct");
      if (f == 5'h01) begin
        chk_out({13'h0, high_rate_o, double_sc_o, coding_256_o}, {13'h0, c[1], c[2], c[0]}, "vic");
      end
      rd_chk(5'h01, d);
    end
    $display("test codes done");
  endtask : test_codes

  task automatic test_txopts;
    wr(5'h01, 8'h0c, 1'h1);
    foreach (txv[i]) begin
      wr(5'h02, txv[i], 1'h1);
      chk_out(tx_cfg, tx_exp(txv[i], 1'h1), "tx b");
      rd_chk(5'h02, txv[i] & 8'hfe);
    end
    wr(5'h01, 8'h08, 1'h1);
    chk_out(tx_cfg, tx_exp(8'h13, 1'h0), "tx not b");
    $display("test txopts done");
  endtask : test_txopts

  task automatic test_enable;
    wr(5'h01, 8'h8b, 1'h1);
    wr(5'h02, 8'hfe, 1'h1);
    // Pin changes on the rising edge like every other input
    @(posedge clock_i);
    enable_i <= 1'h0;
    repeat (6) @(posedge clock_i);
    wr(5'h01, 8'h0c, 1'h0);
    rd_chk(5'h01, 8'h02);
    @(posedge clock_i);
    enable_i <= 1'h1;
    repeat (6) @(posedge clock_i);
    rd_chk(5'h02, 8'h00);
    chk_out(rx_cfg, {4'h0, 5'h01, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0}, "rx preset");
    chk_out(tx_cfg, tx_exp(8'h00, 1'h0), "tx preset");
    wr(5'h03, 8'h55, 1'h1);
    rd_chk(5'h03, 8'h00);
    rd_chk(5'h01, 8'h02);
    $display("test enable done");
  endtask : test_enable

  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // Main sequence, reset held four cycles
  initial begin
    rst_i = 1'h1;
    enable_i = 1'h1;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'h0;
    repeat (6) @(posedge clock_i);
    test_reset();
    test_codes();
    test_txopts();
    test_enable();
    final_report();
  end

  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #(20000 * 25);
    n_mismatch++;
    final_report();
  end
endmodule : protocol_select_config_tb_top

`default_nettype wire
